// ===== hw/sync_source_selector_cfg.svh
/*
 * Constants for the sample-clock source selector: encodings, reset values
 * and flash image layout. Assumes inclusion by the package and the module.
 */
`ifndef SYNC_SOURCE_SELECTOR_CFG_SVH
`define SYNC_SOURCE_SELECTOR_CFG_SVH

// ****************************************
// Encodings
// ****************************************
`define ST_NO_LOCK      2'h0
`define ST_LOCK         2'h1
`define ST_SYNC         2'h2
`define SRC_WORD        2'h0
`define SRC_OPTICAL     2'h1
`define SRC_COAX        2'h2
`define SRC_INTERNAL    2'h3
`define SPEED_SINGLE    2'h0
`define SPEED_DOUBLE    2'h1
`define SPEED_QUAD      2'h2

// ****************************************
// Reset values and flash image fields
// ****************************************
`define RST_AUTO_MODE   1'h0
`define RST_PREF_SRC    2'h0
`define RST_SINGLE_LIM  1'h0
`define CFG_W           4
`define CFG_AUTO_BIT    0
`define CFG_PREF_LSB    1
`define CFG_LIMIT_BIT   3

`endif

// ===== hw/sync_source_selector_pkg.sv
/*
 * Types shared by the source selector.
 * Assumes the constants header is present.
 */
`include "sync_source_selector_cfg.svh"
package sync_source_selector_pkg;
	typedef logic [1:0] lock_state_t;
	typedef logic [1:0] source_t;
	typedef enum logic [2:0] {
		SEL_MASTER = 3'h1,
		SEL_SLAVE  = 3'h2,
		SEL_SETTLE = 3'h4
	} sel_state_e;
endpackage

// ===== hw/sync_source_selector.sv
/*
 * Sample-clock source selection, word clock divider control, status
 * reporting and flash store/recall of configuration.
 * Assumes lock flags and rates come from clock recovery off mclk's domain,
 * and the flash controller handshakes on mclk.
 */
`timescale 1ns/1ps
`include "sync_source_selector_cfg.svh"
module sync_source_selector #(
	parameter int RATE_W  = 18,
	parameter int ERR_W   = 16
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Host configuration
	input  wire logic                 cfg_write,
	input  wire logic                 cfg_auto_mode,
	input  wire logic [1:0]           cfg_pref_src,
	input  wire logic                 cfg_single_limit,
	input  wire logic                 cmd_store,
	input  wire logic                 cmd_recall,
	// Flash port
	output logic                      flash_wr,
	output logic [`CFG_W-1:0]         flash_wdata,
	input  wire logic [`CFG_W-1:0]    flash_rdata,
	// Recovered input status, asynchronous
	input  wire logic [2:0]           in_lock,
	input  wire logic [2:0]           in_sync,
	input  wire logic [RATE_W-1:0]    coax_rate,
	input  wire logic [RATE_W-1:0]    word_rate,
	input  wire logic [RATE_W-1:0]    optical_rate,
	input  wire logic [RATE_W-1:0]    internal_rate,
	input  wire logic [1:0]           rate_speed,
	// Transfer error events
	input  wire logic                 xfer_error,
	input  wire logic                 stream_start,
	// Clock steering
	output logic [1:0]                clk_select,
	output logic [1:0]                wclk_div_sel,
	// Status
	output logic                      automatic_source_mode,
	output logic [1:0]                pref_src,
	output logic                      single_limit,
	output logic [5:0]                per_input_lock_status,
	output logic [1:0]                active_reference_report,
	output logic [RATE_W-1:0]         active_ref_rate,
	output logic                      slave_state,
	output logic [RATE_W-1:0]         coax_rate_report,
	output logic [ERR_W-1:0]          error_count,
	output logic                      error_flag
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0] lock_s1, lock_s2, lock_s3, lock_q;
	logic [2:0] sync_s1, sync_s2, sync_s3, sync_q;

	always_ff @(posedge mclk) begin
		lock_s1 <= in_lock;
		lock_s2 <= lock_s1;
		lock_s3 <= lock_s2;
		sync_s1 <= in_sync;
		sync_s2 <= sync_s1;
		sync_s3 <= sync_s2;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (lock_s2[i] == lock_s3[i]) begin
					lock_q[i] <= lock_s2[i];
				end
				if (sync_s2[i] == sync_s3[i]) begin
					sync_q[i] <= sync_s2[i];
				end
			end
		end
	end

	// ****************************************
	// Rate word capture
	// ****************************************
	logic [RATE_W-1:0] word_rate_s1, word_rate_s2, word_rate_s3, word_rate_q;
	logic [RATE_W-1:0] opt_rate_s1, opt_rate_s2, opt_rate_s3, opt_rate_q;
	logic [RATE_W-1:0] coax_rate_s1, coax_rate_s2, coax_rate_s3, coax_rate_q;
	logic [RATE_W-1:0] int_rate_s1, int_rate_s2, int_rate_s3, int_rate_q;
	logic [1:0]        speed_s1, speed_s2, speed_s3, speed_q;
	logic              word_rate_ok;
	logic              opt_rate_ok;
	logic              coax_rate_ok;
	logic              int_rate_ok;
	logic              speed_ok;

	always_ff @(posedge mclk) begin
		word_rate_s1 <= word_rate;
		word_rate_s2 <= word_rate_s1;
		word_rate_s3 <= word_rate_s2;
		opt_rate_s1  <= optical_rate;
		opt_rate_s2  <= opt_rate_s1;
		opt_rate_s3  <= opt_rate_s2;
		coax_rate_s1 <= coax_rate;
		coax_rate_s2 <= coax_rate_s1;
		coax_rate_s3 <= coax_rate_s2;
		int_rate_s1  <= internal_rate;
		int_rate_s2  <= int_rate_s1;
		int_rate_s3  <= int_rate_s2;
		speed_s1     <= rate_speed;
		speed_s2     <= speed_s1;
		speed_s3     <= speed_s2;
	end

	assign word_rate_ok = (word_rate_s2 == word_rate_s3);
	assign opt_rate_ok  = (opt_rate_s2 == opt_rate_s3);
	assign coax_rate_ok = (coax_rate_s2 == coax_rate_s3);
	assign int_rate_ok  = (int_rate_s2 == int_rate_s3);
	assign speed_ok     = (speed_s2 == speed_s3);

	always_ff @(posedge mclk) begin
		if (rst) begin
			word_rate_q <= '0;
			opt_rate_q  <= '0;
			coax_rate_q <= '0;
			int_rate_q  <= '0;
			speed_q     <= `SPEED_SINGLE;
		end else begin
			if (word_rate_ok) begin
				word_rate_q <= word_rate_s2;
			end
			if (opt_rate_ok) begin
				opt_rate_q <= opt_rate_s2;
			end
			if (coax_rate_ok) begin
				coax_rate_q <= coax_rate_s2;
			end
			if (int_rate_ok) begin
				int_rate_q <= int_rate_s2;
			end
			if (speed_ok) begin
				speed_q <= speed_s2;
			end
		end
	end

	// ****************************************
	// Configuration and flash
	// ****************************************
	logic              recall_pend;
	logic [`CFG_W-1:0] cur_cfg;
	logic [1:0]        cfg_pref_fixed;

	assign cur_cfg        = {single_limit, pref_src, automatic_source_mode};
	assign cfg_pref_fixed = (cfg_pref_src == `SRC_INTERNAL) ? `SRC_WORD : cfg_pref_src;

	always_ff @(posedge mclk) begin
		if (rst) begin
			automatic_source_mode <= `RST_AUTO_MODE;
			pref_src              <= `RST_PREF_SRC;
			single_limit          <= `RST_SINGLE_LIM;
			recall_pend           <= 1'h0;
			flash_wr              <= 1'h0;
			flash_wdata           <= '0;
		end else begin
			flash_wr    <= cmd_store;
			flash_wdata <= cur_cfg;
			recall_pend <= cmd_recall;
			if (recall_pend) begin
				automatic_source_mode <= flash_rdata[`CFG_AUTO_BIT];
				pref_src    <= flash_rdata[`CFG_PREF_LSB +: 2];
				single_limit <= flash_rdata[`CFG_LIMIT_BIT];
			end else if (cfg_write) begin
				automatic_source_mode <= cfg_auto_mode;
				pref_src     <= cfg_pref_fixed;
				single_limit <= cfg_single_limit;
			end
		end
	end

	// ****************************************
	// Source choice
	// ****************************************
	function automatic logic [1:0] next_avail(input logic [1:0] pref, input logic [2:0] ok);
		logic [1:0] p;
		logic [1:0] a;
		logic [1:0] b;
		p = (pref == `SRC_INTERNAL) ? `SRC_WORD : pref;
		a = (p == `SRC_COAX) ? `SRC_WORD : p + 2'h1;
		b = (a == `SRC_COAX) ? `SRC_WORD : a + 2'h1;
		if (ok[p]) begin
			next_avail = p;
		end else if (ok[a]) begin
			next_avail = a;
		end else if (ok[b]) begin
			next_avail = b;
		end else begin
			next_avail = `SRC_INTERNAL;
		end
	endfunction

	sync_source_selector_pkg::sel_state_e state, next_state;
	logic [1:0] cand;
	logic [1:0] next_clk_select;
	logic       cur_ok;

	assign cand   = next_avail(pref_src, lock_q);
	assign cur_ok = (clk_select != `SRC_INTERNAL) && lock_q[clk_select];

	always_comb begin
		next_state      = state;
		next_clk_select = clk_select;
		case (state)
			sync_source_selector_pkg::SEL_MASTER: begin
				if (automatic_source_mode && cand != `SRC_INTERNAL) begin
					next_state = sync_source_selector_pkg::SEL_SETTLE;
				end
			end
			sync_source_selector_pkg::SEL_SLAVE: begin
				if (!automatic_source_mode) begin
					next_state      = sync_source_selector_pkg::SEL_MASTER;
					next_clk_select = `SRC_INTERNAL;
				end else if (!cur_ok || cand != clk_select) begin
					next_state = sync_source_selector_pkg::SEL_SETTLE;
				end
			end
			default: begin
				if (!automatic_source_mode || cand == `SRC_INTERNAL) begin
					next_state      = sync_source_selector_pkg::SEL_MASTER;
					next_clk_select = `SRC_INTERNAL;
				end else if (lock_q[cand]) begin
					next_state      = sync_source_selector_pkg::SEL_SLAVE;
					next_clk_select = cand;
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state      <= sync_source_selector_pkg::SEL_MASTER;
			clk_select <= `SRC_INTERNAL;
		end else begin
			state      <= next_state;
			clk_select <= next_clk_select;
		end
	end

	// ****************************************
	// Status and word clock
	// ****************************************
	function automatic logic [1:0] in_status(input logic l, input logic s);
		in_status = !l ? `ST_NO_LOCK : (s ? `ST_SYNC : `ST_LOCK);
	endfunction

	logic [RATE_W-1:0] sel_rate;
	logic [1:0]        next_div;

	assign sel_rate = (clk_select == `SRC_WORD)    ? word_rate_q :
	                  (clk_select == `SRC_OPTICAL) ? opt_rate_q :
	                  (clk_select == `SRC_COAX)    ? coax_rate_q : int_rate_q;
	assign next_div = single_limit ? speed_q : `SPEED_SINGLE;

	always_ff @(posedge mclk) begin
		if (rst) begin
			per_input_lock_status   <= 6'h00;
			active_reference_report <= `SRC_INTERNAL;
			active_ref_rate         <= '0;
			slave_state             <= 1'h0;
			coax_rate_report        <= '0;
			wclk_div_sel            <= `SPEED_SINGLE;
		end else begin
			for (int i = 0; i < 3; i++) begin
				per_input_lock_status[2*i +: 2] <= in_status(lock_q[i], sync_q[i]);
			end
			active_reference_report <= clk_select;
			active_ref_rate         <= sel_rate;
			slave_state  <= (state == sync_source_selector_pkg::SEL_SLAVE);
			coax_rate_report <= coax_rate_q;
			wclk_div_sel <= next_div;
		end
	end

	// ****************************************
	// Transfer errors
	// ****************************************
	logic err_full;

	assign err_full = (error_count == '1);

	always_ff @(posedge mclk) begin
		if (rst) begin
			error_count <= '0;
			error_flag  <= 1'h0;
		end else if (stream_start) begin
			error_count <= ERR_W'(xfer_error);
			error_flag  <= xfer_error;
		end else if (xfer_error) begin
			if (!err_full) begin
				error_count <= error_count + 1'b1;
			end
			error_flag <= 1'h1;
		end
	end

endmodule

// ===== bench/sync_source_selector_checker.sv
/* Port assertions for the source selector.
   Assumes a bind from the bench top and reset held over several edges. */
`timescale 1ns/1ps
`include "sync_source_selector_cfg.svh"
module sync_source_selector_checker #(
	parameter int RATE_W = 18,
	parameter int ERR_W  = 16
) (
	// Requests
	input wire logic               mclk,
	input wire logic               rst,
	input wire logic               cfg_write,
	input wire logic               cfg_auto_mode,
	input wire logic               cmd_store,
	input wire logic               cmd_recall,
	input wire logic               xfer_error,
	input wire logic               stream_start,
	input wire logic [2:0]         in_lock,
	input wire logic [`CFG_W-1:0]  flash_rdata,
	// Outputs
	input wire logic               flash_wr,
	input wire logic [`CFG_W-1:0]  flash_wdata,
	input wire logic [1:0]         clk_select,
	input wire logic               automatic_source_mode,
	input wire logic [1:0]         pref_src,
	input wire logic               single_limit,
	input wire logic [1:0]         active_reference_report,
	input wire logic               slave_state,
	input wire logic [ERR_W-1:0]   error_count,
	input wire logic               error_flag
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_cfg_apply: assert property (
		cfg_write && !cmd_recall && !$past(cmd_recall)
		|=> automatic_source_mode == $past(cfg_auto_mode))
		else $error("config write not applied");
	a_store_pulse: assert property (!$past(rst) |-> flash_wr == $past(cmd_store))
		else $error("store pulse wrong");
	a_store_data: assert property (
		cmd_store |=> flash_wdata == {$past(single_limit), $past(pref_src),
		$past(automatic_source_mode)}) else $error("store image wrong");
	a_recall_load: assert property (
		cmd_recall |-> ##[2:3] {single_limit, pref_src, automatic_source_mode} == flash_rdata)
		else $error("recall not loaded");
	a_master_internal: assert property (
		!automatic_source_mode [*6] |-> clk_select == 2'h3 && !slave_state)
		else $error("master mode not on internal clock");
	a_lock_only: assert property (
		$changed(clk_select) && clk_select != 2'h3
		|-> (($past(in_lock, 4) | $past(in_lock, 5)) >> clk_select) & 3'h1)
		else $error("switched to unlocked input");
	a_slave_ref: assert property ($rose(slave_state) |-> active_reference_report != 2'h3)
		else $error("slave without reference");
	a_err_clear: assert property (
		stream_start && !xfer_error |=> error_count == '0 && !error_flag)
		else $error("errors not cleared");
	a_err_start_hit: assert property (
		stream_start && xfer_error |=> error_count == ERR_W'(1) && error_flag)
		else $error("error at start lost");
	a_err_count: assert property (
		xfer_error && !stream_start && error_count != '1
		|=> error_count == $past(error_count) + 1'b1 && error_flag) else $error("error not counted");
	c_slave: cover property ($rose(slave_state));
	c_recall: cover property (cmd_recall);
	c_error: cover property (error_flag);
endmodule

// ===== bench/audio_source_model.sv
/* Far side: recovered-clock sources and the configuration flash.
   Assumes the bench sets lock and sync requests on mclk. */
`timescale 1ns/1ps
`include "sync_source_selector_cfg.svh"
module audio_source_model (
	// Bench control
	input wire logic               mclk,
	input wire logic [2:0]         lock_req,
	input wire logic [2:0]         sync_req,
	// Source side
	output logic [2:0]             in_lock,
	output logic [2:0]             in_sync,
	output logic [17:0]            word_rate,
	output logic [17:0]            optical_rate,
	output logic [17:0]            coax_rate,
	// Flash side
	input wire logic               flash_wr,
	input wire logic [`CFG_W-1:0]  flash_wdata,
	output logic [`CFG_W-1:0]      flash_rdata
);
	assign in_lock = lock_req;
	assign in_sync = sync_req & lock_req;
	assign word_rate = 18'h0AC44;
	assign optical_rate = 18'h17700;
	assign coax_rate = 18'h2EE00;
	logic [`CFG_W-1:0] flash_cell = 4'hA;
	assign flash_rdata = flash_cell;
	always @(posedge mclk) if (flash_wr) flash_cell <= flash_wdata;
endmodule

// ===== bench/sync_source_selector_tb_top.sv
/* Bench top: config, command and source steps with expected values.
   Assumes the checker and far-side model files. */
`timescale 1ns/1ps
`include "sync_source_selector_cfg.svh"
module sync_source_selector_tb_top;
	logic        mclk = 0, rst = 1, cfg_write = 0, cfg_auto_mode = 0, cfg_single_limit = 0;
	logic        cmd_store = 0, cmd_recall = 0, xfer_error = 0, stream_start = 0;
	logic        flash_wr, automatic_source_mode, single_limit, slave_state, error_flag;
	logic [1:0]  cfg_pref_src = 0, rate_speed = 0, clk_select, wclk_div_sel, pref_src;
	logic [1:0]  active_reference_report;
	logic [2:0]  lock_req = 0, sync_req = 0, in_lock, in_sync;
	logic [3:0]  flash_wdata, flash_rdata;
	logic [5:0]  per_input_lock_status;
	logic [15:0] error_count;
	logic [17:0] internal_rate = 18'h0BB80, word_rate, optical_rate, coax_rate;
	logic [17:0] active_ref_rate, coax_rate_report;
	int          miscompares = 0, n_compared = 0;
	// ****************
	// Instances and tasks
	// ****************
	sync_source_selector dut_u (
		.mclk(mclk), .rst(rst), .cfg_write(cfg_write), .cfg_auto_mode(cfg_auto_mode),
		.cfg_pref_src(cfg_pref_src), .cfg_single_limit(cfg_single_limit),
		.cmd_store(cmd_store), .cmd_recall(cmd_recall), .flash_wr(flash_wr),
		.flash_wdata(flash_wdata), .flash_rdata(flash_rdata), .in_lock(in_lock),
		.in_sync(in_sync), .coax_rate(coax_rate), .word_rate(word_rate),
		.optical_rate(optical_rate), .internal_rate(internal_rate), .rate_speed(rate_speed),
		.xfer_error(xfer_error), .stream_start(stream_start), .clk_select(clk_select),
		.wclk_div_sel(wclk_div_sel), .automatic_source_mode(automatic_source_mode),
		.pref_src(pref_src), .single_limit(single_limit),
		.per_input_lock_status(per_input_lock_status),
		.active_reference_report(active_reference_report), .active_ref_rate(active_ref_rate),
		.slave_state(slave_state), .coax_rate_report(coax_rate_report),
		.error_count(error_count), .error_flag(error_flag)
	);
	audio_source_model src_u (
		.mclk(mclk), .lock_req(lock_req), .sync_req(sync_req), .in_lock(in_lock),
		.in_sync(in_sync), .word_rate(word_rate), .optical_rate(optical_rate),
		.coax_rate(coax_rate), .flash_wr(flash_wr), .flash_wdata(flash_wdata),
		.flash_rdata(flash_rdata)
	);
	initial forever #12.5 mclk = ~mclk;
	task chk(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cfg(input logic a, input logic [1:0] p, input logic l);
		@(posedge mclk);
		{cfg_write, cfg_auto_mode, cfg_pref_src, cfg_single_limit} <= {1'b1, a, p, l};
		@(posedge mclk);
		cfg_write <= 0;
	endtask
	task pulse(input int k);
		@(posedge mclk);
		{stream_start, xfer_error, cmd_recall, cmd_store} <= 4'h1 << k;
		@(posedge mclk);
		{stream_start, xfer_error, cmd_recall, cmd_store} <= 4'h0;
	endtask
	task wait_sel(input logic [1:0] s);
		int i;
		for (i = 0; i < 40 && !(clk_select === s && slave_state === (s != 2'h3)); i++)
			@(negedge mclk);
		if (i == 40) begin
			miscompares++;
			finish_test();
		end else begin
			@(negedge mclk);
		end
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 0;
		@(posedge mclk) lock_req <= 3'h2;
		@(negedge mclk) chk(clk_select, 2'h3);
		cfg(1, 2'h0, 0);
		wait_sel(2'h1);
		chk(active_reference_report, 2'h1);
		chk(active_ref_rate, optical_rate);
		chk(per_input_lock_status, 6'h04);
		@(posedge mclk) {lock_req, sync_req} <= 6'h39;
		wait_sel(2'h0);
		chk(per_input_lock_status, 6'h16);
		chk(coax_rate_report, coax_rate);
		cfg(1, 2'h1, 0);
		@(negedge mclk) chk(pref_src, 2'h1);
		cfg(1, 2'h3, 0);
		@(negedge mclk) chk(pref_src, 2'h0);
		@(posedge mclk) {lock_req, sync_req} <= 6'h20;
		wait_sel(2'h2);
		@(posedge mclk) lock_req <= 3'h0;
		wait_sel(2'h3);
		chk(active_ref_rate, internal_rate);
		cfg(0, 2'h2, 1);
		@(posedge mclk) lock_req <= 3'h4;
		cfg(1, 2'h2, 1);
		wait_sel(2'h2);
		cfg(0, 2'h2, 1);
		wait_sel(2'h3);
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk) rate_speed <= 2'(k);
			repeat (6) @(negedge mclk);
			chk(wclk_div_sel, 18'(k));
		end
		pulse(0);
		cfg(0, 2'h0, 0);
		repeat (2) @(negedge mclk);
		chk(wclk_div_sel, 2'h0);
		pulse(1);
		repeat (2) @(negedge mclk);
		chk({single_limit, pref_src, automatic_source_mode}, 4'hC);
		repeat (3) pulse(2);
		@(negedge mclk) chk({error_flag, error_count}, 17'h10003);
		pulse(3);
		@(negedge mclk) chk({error_flag, error_count}, 17'h0);
		finish_test();
	end
endmodule
bind sync_source_selector sync_source_selector_checker #(.RATE_W(RATE_W), .ERR_W(ERR_W)) chk_u (
	.mclk(mclk), .rst(rst), .cfg_write(cfg_write), .cfg_auto_mode(cfg_auto_mode),
	.cmd_store(cmd_store), .cmd_recall(cmd_recall), .xfer_error(xfer_error),
	.stream_start(stream_start), .in_lock(in_lock), .flash_rdata(flash_rdata),
	.flash_wr(flash_wr), .flash_wdata(flash_wdata), .clk_select(clk_select),
	.automatic_source_mode(automatic_source_mode), .pref_src(pref_src),
	.single_limit(single_limit), .active_reference_report(active_reference_report),
	.slave_state(slave_state), .error_count(error_count), .error_flag(error_flag)
);
